// ===== rtl/touch_aperture_defs.svh
// Offsets, field positions, reset values and counts of the aperture filter
`ifndef TOUCH_APERTURE_DEFS_SVH
`define TOUCH_APERTURE_DEFS_SVH

`define APER_CFG_ADDR       7'h0B
`define APER_CFG_RST        8'h00
`define XCODE_MSB           7
`define XCODE_LSB           4
`define YCODE_MSB           3
`define YCODE_LSB           0
`define CODE_MAX_ENABLED    4'hC
`define CODE_DISABLED_ZERO  4'h0
`define WORD_POS_MSB        15
`define WORD_POS_LSB        4
`define WORD_MEAS_MSB       3
`define WORD_MEAS_LSB       2
`define WORD_EVT_MSB        1
`define WORD_EVT_LSB        0
`define WORDS_MIN_M1        2'h1

`endif

// ===== rtl/touch_aperture_pkg.sv
// Types shared by the aperture filter modules
package touch_aperture_pkg;

  typedef enum logic [1:0] {
    EVT_INITIAL = 2'b00,
    EVT_MID     = 2'b01,
    EVT_RELEASE = 2'b10,
    EVT_EOF     = 2'b11
  } event_t;

  typedef enum logic [1:0] {
    MEAS_X  = 2'b00,
    MEAS_Y  = 2'b01,
    MEAS_P1 = 2'b10,
    MEAS_P2 = 2'b11
  } meas_t;

  typedef enum logic [1:0] {
    SCAN_XY     = 2'b00,
    SCAN_XYP1   = 2'b01,
    SCAN_XYP1P2 = 2'b10
  } scan_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EMIT = 1'b1
  } state_t;

endpackage : touch_aperture_pkg

// ===== rtl/aperture_window_check.sv
// One axis of the aperture test: code decode and distance compare
`timescale 1ns/1ps
`include "touch_aperture_defs.svh"
module aperture_window_check
  import touch_aperture_pkg::*;
(
  input  wire logic [3:0]  code,
  input  wire logic [11:0] current,
  input  wire logic [11:0] reference,
  output logic             enabled,
  output logic [11:0]      halfWidth,
  output logic             passed
);

  // Half-width is 2^(n-1); only codes 1..12 give a window
  function automatic logic [11:0] decode_width(input logic [3:0] n);
    logic [11:0] w;
    w = 12'h000;
    if (n != `CODE_DISABLED_ZERO && n <= `CODE_MAX_ENABLED) begin
      w = 12'h001 << (n - 4'h1);
    end
    return w;
  endfunction : decode_width

  logic [11:0] distance;

  always_comb begin
    enabled   = (code != `CODE_DISABLED_ZERO) && (code <= `CODE_MAX_ENABLED);
    halfWidth = decode_width(code);
    // Unsigned magnitude so both directions qualify alike
    distance  = (current >= reference) ? (current - reference) : (reference - current);
    passed    = enabled && (distance >= halfWidth);
  end

endmodule : aperture_window_check

// ===== rtl/fifo_word_packer.sv
// Builds one tagged 16-bit result word
`timescale 1ns/1ps
`include "touch_aperture_defs.svh"
module fifo_word_packer
  import touch_aperture_pkg::*;
(
  input  wire logic [11:0] sample,
  input  wire logic        conv8Bit,
  input  wire logic        avgOn,
  input  wire meas_t       meas,
  input  wire event_t      evt,
  output logic [15:0]      word
);

  logic [11:0] position;

  always_comb begin
    // Averaging leaves remainder bits below an 8-bit result
    position = (conv8Bit && !avgOn) ? {sample[11:4], 4'h0} : sample;
    word = 16'h0000;
    word[`WORD_POS_MSB:`WORD_POS_LSB]   = position;
    word[`WORD_MEAS_MSB:`WORD_MEAS_LSB] = meas;
    word[`WORD_EVT_MSB:`WORD_EVT_LSB]   = evt;
  end

endmodule : fifo_word_packer

// ===== rtl/touch_aperture_fifo_filter.sv
// Aperture filter and tagging stage between scan sequencer and result FIFO
`timescale 1ns/1ps
`include "touch_aperture_defs.svh"
module touch_aperture_fifo_filter
  import touch_aperture_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [6:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData_q,
  input  wire logic        autoMode,
  input  wire logic        conv8Bit,
  input  wire logic        avgOn,
  input  wire scan_t       scanType,
  input  wire logic        blockValid,
  input  wire logic        touchAtStart,
  input  wire logic        touchAtEnd,
  input  wire logic [11:0] sampleX,
  input  wire logic [11:0] sampleY,
  input  wire logic [11:0] sampleP1,
  input  wire logic [11:0] sampleP2,
  input  wire logic        fifoFull,
  input  wire logic        fifoEmpty,
  output logic             fifoWrValid_q,
  output logic [15:0]      fifoWrData_q,
  output logic             fifoBlockEnd_q,
  output logic             fifoClear_q,
  output logic             touchIrqLine_q,
  output logic             overflow_q
);

  logic [7:0]  apertureCfg_q;
  logic        autoPrev_q;
  logic        prevTouch_q;
  state_t      state_q;
  logic [1:0]  wordIdx_q;
  logic [1:0]  lastIdx_q;
  event_t      evt_q;
  logic [11:0] capX_q;
  logic [11:0] capY_q;
  logic [11:0] capP1_q;
  logic [11:0] capP2_q;
  logic [11:0] refX_q;
  logic [11:0] refY_q;

  logic        cfgWrite;
  logic        modeChange;
  logic        clearReq;
  logic        accept;
  logic        xEn;
  logic        yEn;
  logic        xPass;
  logic        yPass;
  logic [11:0] xHalf;
  logic [11:0] yHalf;
  logic        apertureOff;
  event_t      evt_d;
  logic        log_d;
  logic        write_d;
  logic [1:0]  lastIdx_d;
  logic [11:0] wordSample;
  logic [15:0] packedWord;

  assign cfgWrite   = regWrEn && (regAddr == `APER_CFG_ADDR);
  assign modeChange = autoMode != autoPrev_q;
  // A config write or a mode change empties the FIFO and drops any block in flight
  assign clearReq   = cfgWrite || modeChange;
  assign accept     = blockValid && (state_q == ST_IDLE) && !clearReq;

  aperture_window_check xWindow (
    .code      (apertureCfg_q[`XCODE_MSB:`XCODE_LSB]),
    .current   (sampleX),
    .reference (refX_q),
    .enabled   (xEn),
    .halfWidth (xHalf),
    .passed    (xPass)
  );

  aperture_window_check yWindow (
    .code      (apertureCfg_q[`YCODE_MSB:`YCODE_LSB]),
    .current   (sampleY),
    .reference (refY_q),
    .enabled   (yEn),
    .halfWidth (yHalf),
    .passed    (yPass)
  );

  // Setting 0x00 lands here too, since both nibbles are disabled codes
  assign apertureOff = !xEn && !yEn;

  always_comb begin
    evt_d = EVT_MID;
    log_d = 1'b0;
    if (touchAtEnd && !prevTouch_q) begin
      evt_d = EVT_INITIAL;
      log_d = 1'b1;
    end else if (touchAtEnd) begin
      evt_d = EVT_MID;
      log_d = !autoMode || apertureOff || xPass || yPass;
    end else if (prevTouch_q || touchAtStart) begin
      // Tag follows the status at block end, so a short blip is a release
      evt_d = EVT_RELEASE;
      log_d = 1'b1;
    end
  end

  assign write_d = accept && log_d && !fifoFull;

  always_comb begin
    case (scanType)
      SCAN_XY:     lastIdx_d = `WORDS_MIN_M1;
      SCAN_XYP1:   lastIdx_d = 2'h2;
      SCAN_XYP1P2: lastIdx_d = 2'h3;
      default:     lastIdx_d = `WORDS_MIN_M1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      apertureCfg_q <= `APER_CFG_RST;
    end else if (cfgWrite) begin
      apertureCfg_q <= regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      regRdData_q <= 8'h00;
    end else if (regRdEn && regAddr == `APER_CFG_ADDR) begin
      regRdData_q <= apertureCfg_q;
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      autoPrev_q <= 1'b0;
    end else begin
      autoPrev_q <= autoMode;
    end
  end

  // Touch history advances on every accepted block, logged or not
  always_ff @(posedge clock) begin
    if (rst) begin
      prevTouch_q <= 1'b0;
    end else if (modeChange) begin
      prevTouch_q <= 1'b0;
    end else if (accept) begin
      prevTouch_q <= touchAtEnd;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      refX_q <= 12'h000;
      refY_q <= 12'h000;
    end else if (write_d && evt_d != EVT_RELEASE) begin
      refX_q <= sampleX;
      refY_q <= sampleY;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      capX_q  <= 12'h000;
      capY_q  <= 12'h000;
      capP1_q <= 12'h000;
      capP2_q <= 12'h000;
      evt_q   <= EVT_INITIAL;
      lastIdx_q <= `WORDS_MIN_M1;
    end else if (write_d) begin
      capX_q  <= sampleX;
      capY_q  <= sampleY;
      capP1_q <= sampleP1;
      capP2_q <= sampleP2;
      evt_q   <= evt_d;
      lastIdx_q <= lastIdx_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      wordIdx_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          wordIdx_q <= 2'h0;
          if (write_d) begin
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (clearReq || wordIdx_q == lastIdx_q) begin
            state_q   <= ST_IDLE;
            wordIdx_q <= 2'h0;
          end else begin
            wordIdx_q <= wordIdx_q + 2'h1;
          end
        end
        default: begin
          state_q   <= ST_IDLE;
          wordIdx_q <= 2'h0;
        end
      endcase
    end
  end

  always_comb begin
    case (wordIdx_q)
      2'h0:    wordSample = capX_q;
      2'h1:    wordSample = capY_q;
      2'h2:    wordSample = capP1_q;
      2'h3:    wordSample = capP2_q;
      default: wordSample = capX_q;
    endcase
  end

  fifo_word_packer packer (
    .sample   (wordSample),
    .conv8Bit (conv8Bit),
    .avgOn    (avgOn),
    .meas     (meas_t'(wordIdx_q)),
    .evt      (evt_q),
    .word     (packedWord)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      fifoWrValid_q  <= 1'b0;
      fifoWrData_q   <= 16'h0000;
      fifoBlockEnd_q <= 1'b0;
    end else if (state_q == ST_EMIT && !clearReq) begin
      fifoWrValid_q  <= 1'b1;
      fifoWrData_q   <= packedWord;
      fifoBlockEnd_q <= wordIdx_q == lastIdx_q;
    end else begin
      fifoWrValid_q  <= 1'b0;
      fifoBlockEnd_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fifoClear_q <= 1'b0;
    end else begin
      fifoClear_q <= clearReq;
    end
  end

  // Raised with the last word so the host never sees a partial block
  always_ff @(posedge clock) begin
    if (rst) begin
      touchIrqLine_q <= 1'b0;
    end else if (state_q == ST_EMIT && !clearReq && wordIdx_q == lastIdx_q) begin
      touchIrqLine_q <= 1'b1;
    end else if (clearReq) begin
      touchIrqLine_q <= 1'b0;
    end else if (state_q == ST_IDLE && !fifoWrValid_q && fifoEmpty) begin
      touchIrqLine_q <= 1'b0;
    end
  end

  // Clear wins over a set of the same cycle, since clearReq holds accept low
  always_ff @(posedge clock) begin
    if (rst) begin
      overflow_q <= 1'b0;
    end else if (accept && log_d && fifoFull) begin
      overflow_q <= 1'b1;
    end else if (cfgWrite || modeChange) begin
      overflow_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_initial_logged: assert property (write_d && evt_d == EVT_INITIAL |-> ##2 fifoWrValid_q && fifoWrData_q[1:0] == 2'b00)
    else $error("initial touch block not written");
  chk_release_logged: assert property (accept && !touchAtEnd && prevTouch_q && !fifoFull |-> ##2 fifoWrData_q[1:0] == 2'b10)
    else $error("release block not written");
  chk_mid_filtered: assert property (accept && autoMode && touchAtEnd && prevTouch_q && !apertureOff && !xPass && !yPass |=> state_q == ST_IDLE ##1 !fifoWrValid_q)
    else $error("midpress written without meeting aperture");
  chk_irq_with_block: assert property (fifoBlockEnd_q |-> touchIrqLine_q)
    else $error("block written without interrupt");
  chk_irq_holds: assert property (touchIrqLine_q && !fifoEmpty && !clearReq |=> touchIrqLine_q)
    else $error("interrupt dropped with data left");
  chk_meas_order: assert property (fifoWrValid_q && !fifoBlockEnd_q |=> fifoWrValid_q && fifoWrData_q[3:2] == $past(fifoWrData_q[3:2]) + 2'h1)
    else $error("measurement tags out of order");
  chk_event_same: assert property (fifoWrValid_q && !fifoBlockEnd_q |=> fifoWrData_q[1:0] == $past(fifoWrData_q[1:0]))
    else $error("event tag changed inside a block");
  chk_no_eof_tag: assert property (fifoWrValid_q |-> fifoWrData_q[1:0] != 2'b11)
    else $error("end of data tag written");
  chk_overflow_drop: assert property (accept && log_d && fifoFull |=> overflow_q && state_q == ST_IDLE)
    else $error("full FIFO did not drop and flag");
  chk_code_disable: assert property (apertureCfg_q[`XCODE_MSB:`XCODE_LSB] > `CODE_MAX_ENABLED |-> !xEn)
    else $error("high aperture code left axis enabled");
  chk_width_decode: assert property (xEn && apertureCfg_q[`XCODE_MSB:`XCODE_LSB] == 4'hC |-> xHalf == 12'h800)
    else $error("aperture width decoded wrong");
  chk_ref_update: assert property (write_d && evt_d == EVT_MID |=> refX_q == $past(sampleX))
    else $error("reference not moved to logged point");
  chk_y_width: assert property (yEn && apertureCfg_q[`YCODE_MSB:`YCODE_LSB] == 4'h1 |-> yHalf == 12'h001)
    else $error("y aperture width decoded wrong");

  cov_initial: cover property (write_d && evt_d == EVT_INITIAL);
  cov_midpress: cover property (write_d && evt_d == EVT_MID && !apertureOff);
  cov_brief_touch: cover property (write_d && !prevTouch_q && evt_d == EVT_RELEASE);
  cov_overflow: cover property ($rose(overflow_q));

endmodule : touch_aperture_fifo_filter

// ===== test/fifo_host_model.sv
// Result FIFO and host reader standing behind the filter
`timescale 1ns/1ps
module fifo_host_model #(
  parameter int CAP = 4
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic wrValid,
  input  wire logic blockEnd,
  input  wire logic clear,
  input  wire logic hostRead,
  output logic      full,
  output logic      empty_q
);
  int blocks_q;
  // Small depth so that the full case is reached in a few blocks
  assign full = blocks_q >= CAP;
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      blocks_q <= 0;
      empty_q  <= 1'b1;
    end else if (hostRead && blocks_q > 0) begin
      blocks_q <= blocks_q - 1;
      empty_q  <= blocks_q == 1;
    end else begin
      if (wrValid)
        empty_q <= 1'b0;
      if (wrValid && blockEnd)
        blocks_q <= blocks_q + 1;
    end
  end
endmodule : fifo_host_model

// ===== test/tb.sv
// Self-checking bench for the aperture filter and tagging stage
`timescale 1ns/1ps
module tb
  import touch_aperture_pkg::*;
;
  localparam logic [3:0] CODES[3] = '{4'h1, 4'h3, 4'hC};
  localparam logic [7:0] CFGS[5]  = '{8'h00, 8'hDD, 8'hEE, 8'hFF, 8'h0F};
  logic        clock = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, autoMode = 1'b1;
  logic        conv8Bit = 1'b0, avgOn = 1'b0, blockValid = 1'b0, hostRead = 1'b0;
  logic        touchAtStart = 1'b0, touchAtEnd = 1'b0;
  logic [6:0]  regAddr = 7'h00;
  logic [7:0]  regWrData = 8'h00;
  logic [11:0] sampleX = 12'h000, sampleY = 12'h000, sampleP1 = 12'h000, sampleP2 = 12'h000;
  scan_t       scanType = SCAN_XY;
  logic        fifoFull, fifoEmpty, fifoWrValid_q, fifoBlockEnd_q, fifoClear_q, touchIrqLine_q, overflow_q;
  logic [7:0]  regRdData_q;
  logic [15:0] fifoWrData_q;
  logic [16:0] expQ[$];
  int          nErrors = 0;
  int          checks = 0;
  logic [31:0] seed = 32'h0000_0031;

  always #5 clock = ~clock;

  touch_aperture_fifo_filter dut (.clock, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData_q,
    .autoMode, .conv8Bit, .avgOn, .scanType, .blockValid, .touchAtStart, .touchAtEnd, .sampleX, .sampleY,
    .sampleP1, .sampleP2, .fifoFull, .fifoEmpty, .fifoWrValid_q, .fifoWrData_q, .fifoBlockEnd_q,
    .fifoClear_q, .touchIrqLine_q, .overflow_q);
  fifo_host_model #(.CAP(4)) host (.clock, .rst, .wrValid(fifoWrValid_q), .blockEnd(fifoBlockEnd_q),
    .clear(fifoClear_q), .hostRead, .full(fifoFull), .empty_q(fifoEmpty));

  function automatic logic [11:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[11:0];
  endfunction : rnd

  task automatic tally(string what, logic [16:0] e, logic [16:0] g);
    checks++;
    if (e !== g) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : tally
  task automatic cmpWord(string w, logic [16:0] e, logic [16:0] g); tally(w, e, g); endtask : cmpWord
  task automatic cmpReg(string w, logic [7:0] e, logic [7:0] g); tally(w, {9'h000, e}, {9'h000, g}); endtask : cmpReg
  task automatic cmpFlag(string w, logic e, logic g); tally(w, {16'h0000, e}, {16'h0000, g}); endtask : cmpFlag

  task automatic finishTest();
    $display("Counts: %0d checks, %0d mismatches", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finishTest

  task automatic regWr(logic [6:0] a, logic [7:0] d);
    @(negedge clock);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clock);
    regWrEn = 1'b0;
  endtask : regWr

  task automatic regRd(logic [6:0] a, output logic [7:0] d);
    @(negedge clock);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRdEn = 1'b0;
    d = regRdData_q;
  endtask : regRd

  // One scan block; expected words are queued before the block is offered
  task automatic blk(logic st, logic en, logic [11:0] x, logic [11:0] y, logic lg, event_t ev);
    logic [11:0] s[4];
    int n;
    s = '{x, y, rnd(), rnd()};
    n = (scanType == SCAN_XYP1) ? 3 : (scanType == SCAN_XYP1P2) ? 4 : 2;
    if (lg)
      for (int i = 0; i < n; i++)
        expQ.push_back({i == n - 1, conv8Bit && !avgOn ? {s[i][11:4], 4'h0} : s[i], meas_t'(i), ev});
    @(negedge clock);
    blockValid = 1'b1;
    touchAtStart = st;
    touchAtEnd = en;
    sampleX = s[0];
    sampleY = s[1];
    sampleP1 = s[2];
    sampleP2 = s[3];
    @(negedge clock);
    blockValid = 1'b0;
    repeat (n + 3) @(negedge clock);
  endtask : blk

  // Host side: reads whole blocks until the FIFO reports empty
  task automatic drain();
    int k;
    for (k = 0; k < 20 && fifoEmpty !== 1'b1; k++) begin
      cmpFlag("irq held", 1'b1, touchIrqLine_q);
      @(negedge clock);
      hostRead = 1'b1;
      @(negedge clock);
      hostRead = 1'b0;
    end
    for (k = 0; k < 8 && touchIrqLine_q !== 1'b0; k++) @(negedge clock);
    cmpFlag("irq cleared", 1'b0, touchIrqLine_q);
    cmpFlag("all words seen", 1'b1, expQ.size() == 0);
    cmpFlag("fifo drained", 1'b1, fifoEmpty);
    if (touchIrqLine_q !== 1'b0 || fifoEmpty !== 1'b1)
      finishTest();
  endtask : drain

  // Outputs are looked at half a cycle after the edge that launches them
  always @(negedge clock) begin
    if (fifoWrValid_q === 1'b1) begin
      if (expQ.size() == 0)
        cmpWord("unexpected word", ~{fifoBlockEnd_q, fifoWrData_q}, {fifoBlockEnd_q, fifoWrData_q});
      else
        cmpWord("fifo word", expQ.pop_front(), {fifoBlockEnd_q, fifoWrData_q});
      if (fifoBlockEnd_q === 1'b1)
        cmpFlag("irq with block", 1'b1, touchIrqLine_q);
    end
  end

  initial begin
    logic [7:0]  d;
    logic [11:0] x0, y0, h;
    logic [3:0]  c;
    logic        ax;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    regRd(7'h0B, d);
    cmpReg("config reset", 8'h00, d);
    regWr(7'h0B, 8'h5C);
    regWr(7'h0A, 8'hFF);
    regRd(7'h0B, d);
    cmpReg("config", 8'h5C, d);
    regRd(7'h0A, d);
    cmpReg("unmapped", 8'h00, d);
    $display("Test registers done");
    foreach (CFGS[i]) begin
      regWr(7'h0B, CFGS[i]);
      x0 = rnd();
      y0 = rnd();
      blk(1'b0, 1'b1, x0, y0, 1'b1, EVT_INITIAL);
      blk(1'b1, 1'b1, x0, y0, 1'b1, EVT_MID);
      blk(1'b1, 1'b0, x0, y0, 1'b1, EVT_RELEASE);
      drain();
    end
    $display("Test aperture disabled done");
    for (int j = 0; j < 6; j++) begin
      c = CODES[j % 3];
      ax = j < 3;
      regWr(7'h0B, ax ? {c, 4'h0} : {4'h0, c});
      h = 12'h001 << (c - 4'h1);
      x0 = 12'h010 + (rnd() & 12'h07F);
      y0 = 12'h010 + (rnd() & 12'h07F);
      blk(1'b0, 1'b1, x0, y0, 1'b1, EVT_INITIAL);
      blk(1'b1, 1'b1, x0 + (ax ? h - 12'h001 : 12'h800), y0 + (ax ? 12'h800 : h - 12'h001), 1'b0, EVT_MID);
      blk(1'b1, 1'b1, x0 + (ax ? h : 12'h000), y0 + (ax ? 12'h000 : h), 1'b1, EVT_MID);
      blk(1'b1, 1'b1, x0, y0, 1'b1, EVT_MID);
      blk(1'b1, 1'b0, x0, y0, 1'b1, EVT_RELEASE);
      drain();
    end
    $display("Test aperture widths done");
    regWr(7'h0B, 8'h00);
    blk(1'b0, 1'b0, rnd(), rnd(), 1'b0, EVT_RELEASE);
    blk(1'b1, 1'b0, rnd(), rnd(), 1'b1, EVT_RELEASE);
    drain();
    $display("Test brief touch done");
    scanType = SCAN_XYP1P2;
    conv8Bit = 1'b1;
    blk(1'b0, 1'b1, rnd(), rnd(), 1'b1, EVT_INITIAL);
    scanType = SCAN_XYP1;
    avgOn = 1'b1;
    blk(1'b1, 1'b0, rnd(), rnd(), 1'b1, EVT_RELEASE);
    drain();
    scanType = SCAN_XY;
    conv8Bit = 1'b0;
    avgOn = 1'b0;
    $display("Test word formats done");
    autoMode = 1'b0;
    regWr(7'h0B, 8'h33);
    x0 = rnd();
    blk(1'b0, 1'b1, x0, x0, 1'b1, EVT_INITIAL);
    blk(1'b1, 1'b1, x0, x0, 1'b1, EVT_MID);
    blk(1'b1, 1'b0, x0, x0, 1'b1, EVT_RELEASE);
    drain();
    autoMode = 1'b1;
    regWr(7'h0B, 8'h00);
    $display("Test direct mode done");
    blk(1'b0, 1'b1, x0, x0, 1'b1, EVT_INITIAL);
    repeat (3) blk(1'b1, 1'b1, x0, x0, 1'b1, EVT_MID);
    cmpFlag("no overflow yet", 1'b0, overflow_q);
    blk(1'b1, 1'b1, x0, x0, 1'b0, EVT_MID);
    cmpFlag("overflow", 1'b1, overflow_q);
    drain();
    blk(1'b1, 1'b0, x0, x0, 1'b1, EVT_RELEASE);
    drain();
    regWr(7'h0B, 8'h00);
    cmpFlag("overflow cleared", 1'b0, overflow_q);
    blk(1'b0, 1'b1, x0, x0, 1'b1, EVT_INITIAL);
    regWr(7'h0B, 8'h00);
    cmpFlag("clear pulse", 1'b1, fifoClear_q);
    cmpFlag("irq dropped by clear", 1'b0, touchIrqLine_q);
    @(negedge clock);
    cmpFlag("fifo cleared", 1'b1, fifoEmpty);
    $display("Test overflow done");
    finishTest();
  end
endmodule : tb
